// file: crss_pkg.sv
package crss_pkg;

  // timing of the serial clock filter
  localparam int CRSS_CLK_NS      = 50;
  localparam int CRSS_DEGLITCH_NS = 120;
  localparam int CRSS_DEGLITCH_CYC =
    (CRSS_DEGLITCH_NS + CRSS_CLK_NS - 1) / CRSS_CLK_NS;

  // configuration bank layout
  localparam int         CRSS_MEM_AW      = 5;
  localparam logic [7:0] CRSS_REG_COUNT   = 8'h1c;
  localparam logic [7:0] CRSS_REG_RECAL   = 8'h03;
  localparam logic [7:0] CRSS_REG_REVERSE = 8'h05;
  localparam int         CRSS_RECAL_BIT   = 7;
  localparam int         CRSS_REV_BIT     = 3;
  localparam logic [7:0] CRSS_REG_RST     = 8'h00;
  localparam logic [7:0] CRSS_PTR_RST     = 8'h00;

  // bit counting within one byte
  localparam logic [3:0] CRSS_CNT_ZERO = 4'h0;
  localparam logic [3:0] CRSS_CNT_ONE  = 4'h1;
  localparam logic [3:0] CRSS_BIT_LAST = 4'h8;
  localparam logic [7:0] CRSS_PTR_STEP = 8'h01;

  // serial engine states, gray along the write path
  typedef enum logic [3:0] {
    CRSS_IDLE  = 4'h0,
    CRSS_ADDR  = 4'h1,
    CRSS_ACK_A = 4'h3,
    CRSS_REG   = 4'h2,
    CRSS_ACK_R = 4'h6,
    CRSS_WDATA = 4'h7,
    CRSS_ACK_W = 4'h5,
    CRSS_RDATA = 4'h4,
    CRSS_RACK  = 4'hc
  } crss_state_type;

  // write port into the configuration bank
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } crss_wr_type;

endpackage

// file: crss_regmem.sv
`timescale 1ns/100ps
module crss_regmem
  import crss_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire crss_wr_type i_wr,
  input  wire logic [7:0]  i_rd_addr,
  output logic      [7:0]  o_rd_data
);

  logic [7:0] mem_q [2**CRSS_MEM_AW];
  logic       wr_in_bank;
  logic       rd_in_bank;
  logic [CRSS_MEM_AW-1:0] wr_idx;
  logic [CRSS_MEM_AW-1:0] rd_idx;

  // addresses past the bank write nothing and read as zero
  assign wr_in_bank = i_wr.we && (i_wr.addr < CRSS_REG_COUNT);
  assign rd_in_bank = i_rd_addr < CRSS_REG_COUNT;
  assign wr_idx     = i_wr.addr[CRSS_MEM_AW-1:0];
  assign rd_idx     = i_rd_addr[CRSS_MEM_AW-1:0];

  // bank storage, cleared at reset so reads are always defined
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < 2**CRSS_MEM_AW; i++) begin
        mem_q[i] <= CRSS_REG_RST;
      end
    end else if (wr_in_bank) begin
      mem_q[wr_idx] <= i_wr.data;
    end
  end

  // registered read port
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rd_data <= CRSS_REG_RST;
    end else begin
      o_rd_data <= rd_in_bank ? mem_q[rd_idx] : CRSS_REG_RST;
    end
  end

endmodule

// file: crss_slave.sv
`timescale 1ns/100ps

module crss_slave
  import crss_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_core_clk,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic [6:0] i_addr,
  output logic            o_sda,
  output logic            o_sda_oen,
  output logic            o_reverse_order,
  output logic            o_recal_pulse
);

  // pin synchronisers
  logic       scl_m_q, scl_s_q;
  logic       sda_m_q, sda_s_q;
  logic [6:0] addr_m_q, addr_s_q;
  // filter and edge state
  logic [CRSS_DEGLITCH_CYC-1:0] scl_h_q;
  logic [CRSS_DEGLITCH_CYC-1:0] sda_h_q;
  logic       scl_f_q, scl_p_q, sda_p_q;
  // engine state
  crss_state_type state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] tx_q, tx_d;
  logic       oen_q, oen_d;
  logic       rw_q, rw_d;
  logic       nack_q, nack_d;
  logic       rev_q, recal_tgl_q;
  // core-side crossing
  logic       rev_m_q, rev_s_q;
  logic       tgl_m_q, tgl_s_q, tgl_p_q;
  // decode wires
  logic       sda_dl, scl_rise, scl_fall, start_det, stop_det;
  logic       rise_ev, fall_ev, byte_end, addr_hit, rx_state, wr_fire;
  logic [7:0] rd_data;
  crss_wr_type wr;

  // two flops on every pin before anything looks at it
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_m_q  <= 1'h1;
      scl_s_q  <= 1'h1;
      sda_m_q  <= 1'h1;
      sda_s_q  <= 1'h1;
      addr_m_q <= 7'h00;
      addr_s_q <= 7'h00;
    end else begin
      scl_m_q  <= i_scl;
      scl_s_q  <= scl_m_q;
      sda_m_q  <= i_sda;
      sda_s_q  <= sda_m_q;
      addr_m_q <= i_addr;
      addr_s_q <= addr_m_q;
    end
  end

  // scl only flips after it held steady for the whole window
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_h_q <= '1;
      sda_h_q <= '1;
      scl_f_q <= 1'h1;
      scl_p_q <= 1'h1;
      sda_p_q <= 1'h1;
    end else begin
      scl_h_q <= {scl_h_q[CRSS_DEGLITCH_CYC-2:0], scl_s_q};
      sda_h_q <= {sda_h_q[CRSS_DEGLITCH_CYC-2:0], sda_s_q};
      if (&scl_h_q) begin
        scl_f_q <= 1'h1;
      end else if (~|scl_h_q) begin
        scl_f_q <= 1'h0;
      end
      scl_p_q <= scl_f_q;
      sda_p_q <= sda_dl;
    end
  end

  // sda delayed through the same 3-sample window as scl, one clock less than the filtered scl
  assign sda_dl    = sda_h_q[CRSS_DEGLITCH_CYC-1];
  assign scl_rise  = scl_f_q & ~scl_p_q;
  assign scl_fall  = ~scl_f_q & scl_p_q;
  assign start_det = scl_f_q & scl_p_q & sda_p_q & ~sda_dl;
  assign stop_det  = scl_f_q & scl_p_q & ~sda_p_q & sda_dl;
  assign rise_ev   = scl_rise & ~start_det & ~stop_det;
  assign fall_ev   = scl_fall & ~start_det & ~stop_det;
  assign byte_end  = cnt_q == CRSS_BIT_LAST;
  assign addr_hit  = shift_q[7:1] == addr_s_q;
  assign rx_state  = (state_q == CRSS_ADDR) || (state_q == CRSS_REG) ||
                     (state_q == CRSS_WDATA);
  assign wr_fire   = fall_ev && (state_q == CRSS_WDATA) && byte_end;

  // bank write port: data byte lands at the current pointer
  assign wr.we   = wr_fire;
  assign wr.addr = ptr_q;
  assign wr.data = shift_q;

  crss_regmem u_regmem (
    .i_clk     (i_clk),
    .i_rstn    (i_rstn),
    .i_wr      (wr),
    .i_rd_addr (ptr_q),
    .o_rd_data (rd_data)
  );

  // serial engine; sda changes on the filtered fall, and is also released at start and stop
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    shift_d = shift_q;
    ptr_d   = ptr_q;
    tx_d    = tx_q;
    oen_d   = oen_q;
    rw_d    = rw_q;
    nack_d  = nack_q;
    if (stop_det) begin
      state_d = CRSS_IDLE;
      oen_d   = 1'h1;
    end else if (start_det) begin
      state_d = CRSS_ADDR;
      cnt_d   = CRSS_CNT_ZERO;
      oen_d   = 1'h1;
    end else if (rise_ev) begin
      if (rx_state) begin
        shift_d = {shift_q[6:0], sda_dl};
        cnt_d   = cnt_q + CRSS_CNT_ONE;
      end else if (state_q == CRSS_RDATA) begin
        cnt_d = cnt_q + CRSS_CNT_ONE;
      end else if (state_q == CRSS_RACK) begin
        nack_d = sda_dl;
      end
    end else if (fall_ev) begin
      unique case (state_q)
        CRSS_IDLE: begin
        end
        CRSS_ADDR: begin
          if (byte_end && addr_hit) begin
            state_d = CRSS_ACK_A;
            oen_d   = 1'h0;
            rw_d    = shift_q[0];
          end else if (byte_end) begin
            state_d = CRSS_IDLE;
          end
        end
        CRSS_ACK_A: begin
          if (rw_q) begin
            state_d = CRSS_RDATA;
            cnt_d   = CRSS_CNT_ZERO;
            tx_d    = rd_data;
            oen_d   = rd_data[7];
          end else begin
            state_d = CRSS_REG;
            cnt_d   = CRSS_CNT_ZERO;
            oen_d   = 1'h1;
          end
        end
        CRSS_REG: begin
          if (byte_end) begin
            state_d = CRSS_ACK_R;
            oen_d   = 1'h0;
            ptr_d   = shift_q;
          end
        end
        CRSS_ACK_R, CRSS_ACK_W: begin
          state_d = CRSS_WDATA;
          cnt_d   = CRSS_CNT_ZERO;
          oen_d   = 1'h1;
        end
        CRSS_WDATA: begin
          if (byte_end) begin
            state_d = CRSS_ACK_W;
            oen_d   = 1'h0;
            ptr_d   = ptr_q + CRSS_PTR_STEP;
          end
        end
        CRSS_RDATA: begin
          if (byte_end) begin
            state_d = CRSS_RACK;
            oen_d   = 1'h1;
            ptr_d   = ptr_q + CRSS_PTR_STEP;
          end else begin
            tx_d  = {tx_q[6:0], 1'h0};
            oen_d = tx_q[6];
          end
        end
        CRSS_RACK: begin
          if (nack_q) begin
            state_d = CRSS_IDLE;
          end else begin
            state_d = CRSS_RDATA;
            cnt_d   = CRSS_CNT_ZERO;
            tx_d    = rd_data;
            oen_d   = rd_data[7];
          end
        end
        default: begin
          state_d = CRSS_IDLE;
          oen_d   = 1'h1;
        end
      endcase
    end
  end

  // engine registers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= CRSS_IDLE;
      cnt_q   <= CRSS_CNT_ZERO;
      shift_q <= CRSS_REG_RST;
      ptr_q   <= CRSS_PTR_RST;
      tx_q    <= CRSS_REG_RST;
      oen_q   <= 1'h1;
      rw_q    <= 1'h0;
      nack_q  <= 1'h1;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      shift_q <= shift_d;
      ptr_q   <= ptr_d;
      tx_q    <= tx_d;
      oen_q   <= oen_d;
      rw_q    <= rw_d;
      nack_q  <= nack_d;
    end
  end

  // shadows of the two control bits the core needs without a bank read
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rev_q       <= 1'h0;
      recal_tgl_q <= 1'h0;
      o_sda       <= 1'h0;
    end else begin
      if (wr_fire && (ptr_q == CRSS_REG_REVERSE)) begin
        rev_q <= shift_q[CRSS_REV_BIT];
      end
      if (wr_fire && (ptr_q == CRSS_REG_RECAL) &&
          shift_q[CRSS_RECAL_BIT]) begin
        recal_tgl_q <= ~recal_tgl_q;
      end
      o_sda <= 1'h0; // open drain: only the enable moves
    end
  end

  assign o_sda_oen = oen_q;

  // core domain: level through three flops, event as a toggle
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rev_m_q         <= 1'h0;
      rev_s_q         <= 1'h0;
      tgl_m_q         <= 1'h0;
      tgl_s_q         <= 1'h0;
      tgl_p_q         <= 1'h0;
      o_reverse_order <= 1'h0;
      o_recal_pulse   <= 1'h0;
    end else begin
      rev_m_q         <= rev_q;
      rev_s_q         <= rev_m_q;
      tgl_m_q         <= recal_tgl_q;
      tgl_s_q         <= tgl_m_q;
      tgl_p_q         <= tgl_s_q;
      o_reverse_order <= rev_s_q;
      o_recal_pulse   <= tgl_s_q ^ tgl_p_q;
    end
  end

  // checks, all on the crystal clock
  sequence s_byte_fall;
    fall_ev && byte_end;
  endsequence

  a_start_to_addr: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    start_det && !stop_det |=> state_q == CRSS_ADDR && oen_q)
    else $error("start did not open address phase");

  a_scl_filter_delay: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    $rose(scl_f_q) |-> $past(scl_s_q, 2) && $past(scl_s_q, 3) &&
                       $past(scl_s_q, 4))
    else $error("filtered scl rose without three high samples");

  a_sda_on_fall: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    $changed(oen_q) |-> $past(scl_fall) || $past(start_det) ||
                        $past(stop_det))
    else $error("sda changed away from filtered scl fall");

  a_addr_miss_quiet: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    (state_q == CRSS_ADDR && !addr_hit) and s_byte_fall
    |=> state_q == CRSS_IDLE && oen_q)
    else $error("device answered a foreign address");

  a_write_dir: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    (state_q == CRSS_ADDR && addr_hit && !shift_q[0]) and s_byte_fall
    |=> state_q == CRSS_ACK_A && !rw_q ##[1:300] state_q == CRSS_REG)
    else $error("write select did not lead to register phase");

  a_read_advance: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    (state_q == CRSS_RDATA) and s_byte_fall
    |=> ptr_q == $past(ptr_q) + CRSS_PTR_STEP && state_q == CRSS_RACK)
    else $error("pointer not advanced after read byte");

  a_ptr_load: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    (state_q == CRSS_REG) and s_byte_fall |=> ptr_q == $past(shift_q))
    else $error("register address not loaded into pointer");

  a_store_incr: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    wr_fire |-> wr.addr == ptr_q ##1 ptr_q == $past(ptr_q) + CRSS_PTR_STEP)
    else $error("write byte not stored at pointer then incremented");

  a_reverse_bit: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    wr_fire && ptr_q == CRSS_REG_REVERSE
    |=> rev_q == $past(shift_q[CRSS_REV_BIT]))
    else $error("reversal control not taken from bit 3");

  a_ack_low: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    state_q inside {CRSS_ACK_A, CRSS_ACK_R, CRSS_ACK_W} |-> !oen_q)
    else $error("ack slot without sda pulled low");

endmodule

// file: crss_host.sv
`timescale 1ns/100ps
module crss_host (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oen
);
  // quarter bit; keeps both scl phases far above the 3-clock minimum
  localparam int QTR = 10;

  initial begin
    o_scl     = 1'b1;
    o_sda_oen = 1'b1;
  end

  // all moves land on the falling crystal edge
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // sda falls while scl high; also a repeated start
  task automatic start();
    tick(QTR);
    o_sda_oen = 1'b1;
    tick(QTR);
    o_scl = 1'b1;
    tick(QTR);
    o_sda_oen = 1'b0;
    tick(QTR);
    o_scl = 1'b0;
  endtask

  // sda rises while scl high
  task automatic stop();
    tick(QTR);
    o_sda_oen = 1'b0;
    tick(QTR);
    o_scl = 1'b1;
    tick(QTR);
    o_sda_oen = 1'b1;
    tick(QTR);
  endtask

  // a pulse too short for the filter to pass
  task automatic glitch();
    tick(QTR);
    o_scl = 1'b1;
    tick(1);
    o_scl = 1'b0;
  endtask

  // data set mid-low, sampled mid-high, well past the device's update
  task automatic bit_io(input logic b, output logic r);
    tick(QTR);
    o_sda_oen = b;
    tick(QTR);
    o_scl = 1'b1;
    tick(QTR);
    r = i_sda;
    tick(QTR);
    o_scl = 1'b0;
  endtask

  // msb first, ninth clock returns the ack
  task automatic send_byte(input logic [7:0] d, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, ack_n);
  endtask

  // ack low to go on, high on the last byte
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule

// file: tb.sv
`timescale 1ns/100ps
module tb;
  import crss_pkg::*;
  logic       clk, rstn, core_clk, scl, host_oen, sda_o, dev_oen;
  logic       rev, recal, sda;
  logic [6:0] addr;
  int         fail_count, n_checks, recal_seen;

  // wired-and with pull-up: a released line reads high
  assign sda = host_oen & (dev_oen | sda_o);

  crss_host host (.i_clk(clk), .i_sda(sda), .o_scl(scl),
    .o_sda_oen(host_oen));
  crss_slave uut (.i_clk(clk), .i_rstn(rstn), .i_core_clk(core_clk),
    .i_scl(scl), .i_sda(sda), .i_addr(addr), .o_sda(sda_o),
    .o_sda_oen(dev_oen), .o_reverse_order(rev), .o_recal_pulse(recal));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // core clock offset so it never lines up with the crystal
  initial begin
    core_clk = 1'b0;
    #37;
    forever #62.5 core_clk = ~core_clk;
  end

  // looked at mid-cycle, away from the edge that launches the pulse
  always @(negedge core_clk) begin
    if (recal === 1'b1) recal_seen++;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t bit got %b want %b", $time, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t byte got %h want %h", $time, got, exp);
    end
  endtask

  // device's sda enable moves only while the scl pin is low
  always @(dev_oen) begin
    if (rstn === 1'b1) chk1(scl, 1'b0);
  end

  task automatic core_wait();
    repeat (12) @(posedge core_clk);
    @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] r, d0, d1, input int n);
    logic a;
    host.start();
    host.send_byte({addr, 1'b0}, a);
    chk1(a, 1'b0);
    host.send_byte(r, a);
    chk1(a, 1'b0);
    host.send_byte(d0, a);
    chk1(a, 1'b0);
    if (n > 1) begin
      host.send_byte(d1, a);
      chk1(a, 1'b0);
    end
    host.stop();
  endtask

  task automatic rd2(input logic [7:0] r, e0, e1);
    logic       a;
    logic [7:0] d;
    host.start();
    host.send_byte({addr, 1'b0}, a);
    host.send_byte(r, a);
    host.start();
    host.send_byte({addr, 1'b1}, a);
    chk1(a, 1'b0);
    host.recv_byte(1'b0, d);
    chk8(d, e0);
    host.recv_byte(1'b1, d);
    chk8(d, e1);
    host.stop();
  endtask

  // neighbour address must be ignored, its write lost
  task automatic t_wrong_addr();
    logic a;
    host.start();
    host.send_byte({addr ^ 7'h01, 1'b0}, a);
    chk1(a, 1'b1);
    host.send_byte(CRSS_REG_REVERSE, a);
    host.send_byte(8'h08, a);
    host.stop();
    core_wait();
    chk1(rev, 1'b0);
  endtask

  // a short scl spike between bytes must not shift the framing
  task automatic t_glitch();
    logic a;
    host.start();
    host.send_byte({addr, 1'b0}, a);
    host.send_byte(CRSS_REG_REVERSE, a);
    host.glitch();
    host.send_byte(8'h08, a);
    chk1(a, 1'b0);
    host.stop();
    core_wait();
    chk1(rev, 1'b1);
  endtask

  // every bit but the reversal bit, then the bit alone, then read back
  task automatic t_reverse();
    wr(CRSS_REG_REVERSE, 8'hf7, 8'h00, 1);
    core_wait();
    chk1(rev, 1'b0);
    wr(CRSS_REG_REVERSE, 8'h08, 8'ha5, 2);
    core_wait();
    chk1(rev, 1'b1);
    rd2(CRSS_REG_REVERSE, 8'h08, 8'ha5);
  endtask

  // last bank byte kept, the next one past the bank dropped
  task automatic t_bank_edge();
    wr(8'h1b, 8'h3c, 8'h77, 2);
    rd2(8'h1b, 8'h3c, 8'h00);
  endtask

  // bit 7 of the recal register fires once; other bits do not
  task automatic t_recal();
    recal_seen = 0;
    wr(CRSS_REG_RECAL, 8'h80, 8'h00, 1);
    core_wait();
    chk8(8'(recal_seen), 8'h01);
    wr(CRSS_REG_RECAL, 8'h7f, 8'h00, 1);
    core_wait();
    chk8(8'(recal_seen), 8'h01);
  endtask

  initial begin
    fail_count = 0;
    n_checks   = 0;
    recal_seen = 0;
    addr       = 7'h2a;
    rstn       = 1'b0;
    repeat (10) @(negedge clk);
    chk1(dev_oen, 1'b1);
    chk1(sda_o, 1'b0);
    chk1(rev, 1'b0);
    chk1(recal, 1'b0);
    rstn = 1'b1;
    repeat (20) @(negedge clk);
    t_wrong_addr();
    t_glitch();
    t_reverse();
    t_bank_edge();
    t_recal();
    chk1(sda_o, 1'b0);
    test_done();
  end

  // whole run is well under 1 ms of bus traffic
  initial begin
    #2000000;
    fail_count++;
    test_done();
  end
endmodule
